/* File: core/tlic_pkg.sv */
// Purpose: constants and types for the two-level interrupt controller
// Assumes: sources numbered in polling order, 0 is polled first
// Notes: byte address of a register is four times its index
package tlic_pkg;
  localparam int TLIC_NSRC = 11;
  localparam int TLIC_SRC_W = 4;
  localparam int TLIC_ADDR_W = 12;
  // source numbers, polling order
  localparam logic [3:0] SRC_SUPPLY = 4'h0;
  localparam logic [3:0] SRC_WDOG = 4'h1;
  localparam logic [3:0] SRC_EXT0 = 4'h2;
  localparam logic [3:0] SRC_CONV = 4'h3;
  localparam logic [3:0] SRC_T0 = 4'h4;
  localparam logic [3:0] SRC_EXT1 = 4'h5;
  localparam logic [3:0] SRC_T1 = 4'h6;
  localparam logic [3:0] SRC_SPI = 4'h7;
  localparam logic [3:0] SRC_UART = 4'h8;
  localparam logic [3:0] SRC_T2 = 4'h9;
  localparam logic [3:0] SRC_TIC = 4'hA;
  // register indices
  localparam logic [9:0] IDX_MAIN_EN = 10'h0A8;
  localparam logic [9:0] IDX_SECONDARY = 10'h0A9;
  localparam logic [9:0] IDX_LEVEL = 10'h0B8;
  localparam logic [9:0] IDX_WDOG_CTRL = 10'h0C0;
  localparam logic [9:0] IDX_STATUS = 10'h0C1;
  // reset values
  localparam logic [7:0] RST_MAIN_EN = 8'h00;
  localparam logic [7:0] RST_SECONDARY = 8'hA0;
  localparam logic [7:0] RST_LEVEL = 8'h00;
  localparam logic [7:0] RST_WDOG_CTRL = 8'h00;
  // main enable fields
  localparam int B_GLOBAL_EN = 7;
  localparam int B_CONV = 6;
  localparam int B_T2 = 5;
  localparam int B_UART = 4;
  localparam int B_T1 = 3;
  localparam int B_EXT1 = 2;
  localparam int B_T0 = 1;
  localparam int B_EXT0 = 0;
  // secondary fields
  localparam int B_UNIMPL = 7;
  localparam int B_TIC_LVL = 6;
  localparam int B_SUPPLY_LVL = 5;
  localparam int B_SPI_LVL = 4;
  localparam int B_TIC_EN = 2;
  localparam int B_SUPPLY_EN = 1;
  localparam int B_SPI_EN = 0;
  // watchdog control and status fields
  localparam int B_WDOG_EN = 0;
  localparam int B_WDOG_LVL = 1;
  localparam int B_ST_LOW_ACT = 0;
  localparam int B_ST_HIGH_ACT = 1;
  localparam int B_ST_REQ = 2;
  // vector addresses
  localparam logic [15:0] VEC_EXT0 = 16'h0003;
  localparam logic [15:0] VEC_T0 = 16'h000B;
  localparam logic [15:0] VEC_EXT1 = 16'h0013;
  localparam logic [15:0] VEC_T1 = 16'h001B;
  localparam logic [15:0] VEC_UART = 16'h0023;
  localparam logic [15:0] VEC_T2 = 16'h002B;
  localparam logic [15:0] VEC_CONV = 16'h0033;
  localparam logic [15:0] VEC_SPI = 16'h003B;
  localparam logic [15:0] VEC_SUPPLY = 16'h0043;
  localparam logic [15:0] VEC_TIC = 16'h0053;
  localparam logic [15:0] VEC_WDOG = 16'h005B;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [2:0] {
    TLIC_IDLE = 3'b001,
    TLIC_PUSH = 3'b010,
    TLIC_LOAD = 3'b100
  } tlic_state_t;
endpackage

/* File: core/tlic_top.sv */
// Purpose: two-level interrupt controller with an AXI4-Lite register slave
// Assumes: request flags come from logic on aclk; core pulses irq_ack and reti
// Notes: vectoring pushes the pc, then loads the vector, one cycle each
`timescale 1ns/1ps

// Overview of operation
// (R1) bit 7 master enable gates all sources
// (R2) bits 6..4 enable converter, timer2, uart
// (R3) bits 3..0 enable timer1, ext1, timer0, ext0
// (R4) level bits 6..4; bit 7 unimplemented
// (R5) level bits 3..0 for timer1, ext1, timer0, ext0
// (R6) secondary bits 6..4 select three levels
// (R7) software keeps secondary bit 3 zero
// (R8) secondary bits 2..0 enable three sources
// (R9) high level pre-empts a low routine
// (R10) simultaneous high and low: high first
// (R11) same level never pre-empts running routine
// (R12) fixed polling order within one level
// (R13) accept: push pc, then load vector
// (R14) vectors for ext0 through timer2
// (R15) vectors for converter through watchdog
// (R16) watchdog beats ext0 on tie
// (R17) request needs own enable and master enable
module tlic_top
  import tlic_pkg::*;
#(
  parameter int NSRC = tlic_pkg::TLIC_NSRC,
  parameter int ADDR_W = tlic_pkg::TLIC_ADDR_W
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // peripheral request flags, polling order
  input wire logic [NSRC-1:0] src_flags,
  output logic [NSRC-1:0] src_ack,
  // core side
  output logic irq_req,
  input wire logic irq_ack,
  input wire logic reti,
  input wire logic [15:0] cur_pc,
  output logic stack_push,
  output logic [15:0] stack_data,
  output logic pc_load,
  output logic [15:0] pc_value,
  output logic irq_level
);
  import tlic_pkg::*;

  logic [7:0] main_irq_en_reg_r;
  logic [7:0] secondary_reg_r;
  logic [7:0] level_select_reg_r;
  logic [7:0] wdog_ctrl_r;
  logic low_active_r;
  logic high_active_r;
  tlic_state_t state_r;
  logic [15:0] vec_r;
  logic [15:0] pc_r;
  logic level_r;
  logic [NSRC-1:0] src_ack_r;
  logic [NSRC-1:0] src_en;
  logic [NSRC-1:0] src_lvl;
  logic [NSRC-1:0] cand_hi;
  logic [NSRC-1:0] cand_lo;
  logic [TLIC_SRC_W-1:0] win_hi;
  logic [TLIC_SRC_W-1:0] win_lo;
  logic any_hi;
  logic any_lo;
  logic ok_hi;
  logic ok_lo;
  logic take;
  logic take_hi;
  logic [TLIC_SRC_W-1:0] take_src;
  // bus holding state
  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic do_write;
  logic [9:0] wr_idx;
  logic [9:0] rd_idx;
  logic [7:0] status_byte;

  function automatic logic [15:0] vec_of(input logic [TLIC_SRC_W-1:0] s);
    logic [15:0] v;
    v = VEC_EXT0;
    unique case (s)
      // (R14) low vectors
      SRC_EXT0: v = VEC_EXT0;
      SRC_T0: v = VEC_T0;
      SRC_EXT1: v = VEC_EXT1;
      SRC_T1: v = VEC_T1;
      SRC_UART: v = VEC_UART;
      SRC_T2: v = VEC_T2;
      // (R15) upper vectors
      SRC_CONV: v = VEC_CONV;
      SRC_SPI: v = VEC_SPI;
      SRC_SUPPLY: v = VEC_SUPPLY;
      SRC_TIC: v = VEC_TIC;
      SRC_WDOG: v = VEC_WDOG;
      default: v = VEC_EXT0;
    endcase
    return v;
  endfunction

  // per-source enable and level map
  always_comb begin
    src_en = '0;
    src_lvl = '0;
    // (R2) upper main enables
    src_en[SRC_CONV] = main_irq_en_reg_r[B_CONV];
    src_en[SRC_T2] = main_irq_en_reg_r[B_T2];
    src_en[SRC_UART] = main_irq_en_reg_r[B_UART];
    // (R3) lower main enables
    src_en[SRC_T1] = main_irq_en_reg_r[B_T1];
    src_en[SRC_EXT1] = main_irq_en_reg_r[B_EXT1];
    src_en[SRC_T0] = main_irq_en_reg_r[B_T0];
    src_en[SRC_EXT0] = main_irq_en_reg_r[B_EXT0];
    // (R8) secondary enables; watchdog enable from its control register
    src_en[SRC_TIC] = secondary_reg_r[B_TIC_EN];
    src_en[SRC_SUPPLY] = secondary_reg_r[B_SUPPLY_EN];
    src_en[SRC_SPI] = secondary_reg_r[B_SPI_EN];
    src_en[SRC_WDOG] = wdog_ctrl_r[B_WDOG_EN];
    // (R4) upper level bits
    src_lvl[SRC_CONV] = level_select_reg_r[B_CONV];
    src_lvl[SRC_T2] = level_select_reg_r[B_T2];
    src_lvl[SRC_UART] = level_select_reg_r[B_UART];
    // (R5) lower level bits
    src_lvl[SRC_T1] = level_select_reg_r[B_T1];
    src_lvl[SRC_EXT1] = level_select_reg_r[B_EXT1];
    src_lvl[SRC_T0] = level_select_reg_r[B_T0];
    src_lvl[SRC_EXT0] = level_select_reg_r[B_EXT0];
    // (R6) secondary level bits; watchdog level from its control register
    src_lvl[SRC_TIC] = secondary_reg_r[B_TIC_LVL];
    src_lvl[SRC_SUPPLY] = secondary_reg_r[B_SUPPLY_LVL];
    src_lvl[SRC_SPI] = secondary_reg_r[B_SPI_LVL];
    src_lvl[SRC_WDOG] = wdog_ctrl_r[B_WDOG_LVL];
  end

  // (R1) master enable gates every source
  // (R17) flag, own enable and master enable
  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      cand_hi[i] = src_flags[i] & src_en[i] & main_irq_en_reg_r[B_GLOBAL_EN] & src_lvl[i];
      cand_lo[i] = src_flags[i] & src_en[i] & main_irq_en_reg_r[B_GLOBAL_EN] & ~src_lvl[i];
    end
  end

  // (R12) fixed polling order, lowest number wins
  // (R16) watchdog numbered ahead of ext0
  always_comb begin
    win_hi = '0;
    win_lo = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (cand_hi[i]) begin
        win_hi = TLIC_SRC_W'(i);
      end
      if (cand_lo[i]) begin
        win_lo = TLIC_SRC_W'(i);
      end
    end
  end

  assign any_hi = |cand_hi;
  assign any_lo = |cand_lo;
  // (R9) high may pre-empt a low routine
  // (R11) no pre-emption within one level
  assign ok_hi = any_hi & ~high_active_r;
  assign ok_lo = any_lo & ~high_active_r & ~low_active_r;
  // (R10) high request served first
  assign take_hi = ok_hi;
  assign take_src = ok_hi ? win_hi : win_lo;
  assign irq_req = (state_r == TLIC_IDLE) & (ok_hi | ok_lo);
  assign take = irq_req & irq_ack;

  // (R13) push pc, then load vector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= TLIC_IDLE;
    end else begin
      unique case (state_r)
        TLIC_IDLE: begin
          if (take) begin
            state_r <= TLIC_PUSH;
          end
        end
        TLIC_PUSH: state_r <= TLIC_LOAD;
        TLIC_LOAD: state_r <= TLIC_IDLE;
        default: state_r <= TLIC_IDLE;
      endcase
    end
  end

  // capture of vector, pc and level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vec_r <= 16'h0000;
      pc_r <= 16'h0000;
      level_r <= 1'b0;
      src_ack_r <= '0;
    end else begin
      src_ack_r <= '0;
      if (take) begin
        vec_r <= vec_of(take_src);
        pc_r <= cur_pc;
        level_r <= take_hi;
        src_ack_r[take_src] <= 1'b1;
      end
    end
  end

  // in-service levels; return ends the higher one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_active_r <= 1'b0;
      high_active_r <= 1'b0;
    end else begin
      if (take && take_hi) begin
        high_active_r <= 1'b1;
      end else if (reti && high_active_r) begin
        high_active_r <= 1'b0;
      end
      if (take && !take_hi) begin
        low_active_r <= 1'b1;
      end else if (reti && !high_active_r) begin
        low_active_r <= 1'b0;
      end
    end
  end

  assign stack_push = (state_r == TLIC_PUSH);
  assign stack_data = pc_r;
  assign pc_load = (state_r == TLIC_LOAD);
  assign pc_value = vec_r;
  assign irq_level = level_r;
  assign src_ack = src_ack_r;

  // axi write channels, either order
  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready = ~w_held_r & ~bvalid_r;
  assign do_write = aw_held_r & w_held_r & ~bvalid_r;
  assign wr_idx = awaddr_r[11:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (do_write) begin
        bvalid_r <= 1'b1;
        bresp_r <= (wr_idx == IDX_MAIN_EN || wr_idx == IDX_SECONDARY ||
                    wr_idx == IDX_LEVEL || wr_idx == IDX_WDOG_CTRL ||
                    wr_idx == IDX_STATUS) ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // configuration registers, low byte lane
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_irq_en_reg_r <= RST_MAIN_EN;
      secondary_reg_r <= RST_SECONDARY;
      level_select_reg_r <= RST_LEVEL;
      wdog_ctrl_r <= RST_WDOG_CTRL;
    end else if (do_write && wstrb_r[0]) begin
      if (wr_idx == IDX_MAIN_EN) begin
        main_irq_en_reg_r <= wdata_r[7:0];
      end
      // (R7) bit 3 stored as written
      if (wr_idx == IDX_SECONDARY) begin
        secondary_reg_r <= {RST_SECONDARY[B_UNIMPL], wdata_r[6:0]};
      end
      // (R4) bit 7 write ignored
      if (wr_idx == IDX_LEVEL) begin
        level_select_reg_r <= {1'b0, wdata_r[6:0]};
      end
      if (wr_idx == IDX_WDOG_CTRL) begin
        wdog_ctrl_r <= {6'h00, wdata_r[1:0]};
      end
    end
  end

  // read channel
  assign rd_idx = s_axi_araddr[11:2];
  assign s_axi_arready = ~rvalid_r;

  always_comb begin
    status_byte = 8'h00;
    status_byte[B_ST_LOW_ACT] = low_active_r;
    status_byte[B_ST_HIGH_ACT] = high_active_r;
    status_byte[B_ST_REQ] = irq_req;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_r <= 1'b1;
        rresp_r <= RESP_OKAY;
        unique case (rd_idx)
          IDX_MAIN_EN: rdata_r <= {24'h000000, main_irq_en_reg_r};
          IDX_SECONDARY: rdata_r <= {24'h000000, secondary_reg_r};
          IDX_LEVEL: rdata_r <= {24'h000000, level_select_reg_r};
          IDX_WDOG_CTRL: rdata_r <= {24'h000000, wdog_ctrl_r};
          IDX_STATUS: rdata_r <= {24'h000000, status_byte};
          default: begin
            rdata_r <= 32'h00000000;
            rresp_r <= RESP_DECERR;
          end
        endcase
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
endmodule

/* File: verification/tlic_monitor.sv */
// Purpose: port checker for the interrupt controller
// Assumes: one aclk domain
// Notes: bound to tlic_top
`timescale 1ns/1ps
module tlic_monitor
  import tlic_pkg::*;
#(
  parameter int NSRC = 11,
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // sources
  input wire logic [NSRC-1:0] src_flags,
  input wire logic [NSRC-1:0] src_ack,
  // core side
  input wire logic irq_req,
  input wire logic irq_ack,
  input wire logic [15:0] cur_pc,
  input wire logic stack_push,
  input wire logic [15:0] stack_data,
  input wire logic pc_load,
  input wire logic [15:0] pc_value
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_acc;
    irq_req && irq_ack;
  endsequence
  sequence s_vec;
    stack_push ##1 pc_load;
  endsequence
  property p_vec_seq;
    s_acc |=> s_vec;
  endproperty
  a_vec_seq: assert property (p_vec_seq) else $error("push then load broken");
  property p_push_pc;
    s_acc |=> stack_data == $past(cur_pc);
  endproperty
  a_push_pc: assert property (p_push_pc) else $error("pushed pc wrong");
  property p_busy;
    s_acc |=> !irq_req [*2];
  endproperty
  a_busy: assert property (p_busy) else $error("request during vectoring");
  property p_onehot;
    s_acc |=> $onehot(src_ack);
  endproperty
  a_onehot: assert property (p_onehot) else $error("ack not one-hot");
  property p_ack_cause;
    src_ack != '0 |-> $past(irq_req && irq_ack);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without accept");
  property p_ack_flag;
    src_ack != '0 |-> (src_ack & $past(src_flags)) == src_ack;
  endproperty
  a_ack_flag: assert property (p_ack_flag) else $error("ack of idle source");
  property p_no_flag;
    src_flags == '0 |-> !irq_req;
  endproperty
  a_no_flag: assert property (p_no_flag) else $error("request with no flag");
  property p_wdog_vec;
    src_ack[SRC_WDOG] |=> pc_value == VEC_WDOG;
  endproperty
  a_wdog_vec: assert property (p_wdog_vec) else $error("watchdog vector");
  property p_ext0_vec;
    src_ack[SRC_EXT0] |=> pc_value == VEC_EXT0;
  endproperty
  a_ext0_vec: assert property (p_ext0_vec) else $error("ext0 vector");
endmodule
bind tlic_top tlic_monitor #(.NSRC(NSRC), .ADDR_W(ADDR_W)) u_mon (.*);

/* File: verification/tlic_core_model.sv */
// Purpose: core and request flag model
// Assumes: bench raises flags, acceptance clears them
// Notes: acknowledge follows ack_on, pc counts every cycle
`timescale 1ns/1ps
module tlic_core_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bench control
  input wire logic [tlic_pkg::TLIC_NSRC-1:0] raise,
  input wire logic ack_on,
  // controller side
  input wire logic irq_req,
  input wire logic [tlic_pkg::TLIC_NSRC-1:0] src_ack,
  output logic irq_ack,
  output logic [15:0] cur_pc,
  output logic [tlic_pkg::TLIC_NSRC-1:0] src_flags
);
  always_ff @(posedge aclk) begin
    if (!aresetn) src_flags <= '0;
    else src_flags <= (src_flags & ~src_ack) | raise;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) cur_pc <= 16'h1000;
    else cur_pc <= cur_pc + 16'h0001;
  end
  assign irq_ack = ack_on & irq_req;
endmodule

/* File: verification/tb.sv */
// Purpose: self-checking bench for the interrupt controller
// Assumes: core model acks while ack_on is high
// Notes: byte address is four times the index
`timescale 1ns/1ps
module tb;
  import tlic_pkg::*;
  localparam logic [11:0] A_MAIN = {IDX_MAIN_EN, 2'h0};
  localparam logic [11:0] A_SEC = {IDX_SECONDARY, 2'h0};
  localparam logic [11:0] A_LVL = {IDX_LEVEL, 2'h0};
  localparam logic [11:0] A_WDG = {IDX_WDOG_CTRL, 2'h0};
  localparam logic [11:0] A_STS = {IDX_STATUS, 2'h0};
  localparam logic [15:0] VT [0:10] = '{VEC_SUPPLY, VEC_WDOG, VEC_EXT0, VEC_CONV, VEC_T0,
    VEC_EXT1, VEC_T1, VEC_SPI, VEC_UART, VEC_T2, VEC_TIC};
  logic aclk, aresetn, irq_req, irq_ack, reti, stack_push, pc_load, irq_level, ack_on;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [10:0] src_flags, src_ack, raise;
  logic [15:0] cur_pc, stack_data, pc_value;
  int err_total, num_checks;
  tlic_top DUT (.*);
  tlic_core_model u_core (.*);
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic conclude();
    if (err_total == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw, tr;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tr = s_axi_bvalid;
      if (tr) chk("bresp", s_axi_bresp, er);
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!tr);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
    logic ta, tr;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      if (tr) chk("rdata", s_axi_rdata, {24'h0, e});
      if (tr) chk("rresp", s_axi_rresp, er);
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!tr);
  endtask
  task automatic fire(input logic [10:0] m);
    raise <= m;
    @(posedge aclk);
    raise <= '0;
  endtask
  task automatic ret();
    reti <= 1'b1;
    @(posedge aclk);
    reti <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic idle(input logic e);
    repeat (4) @(negedge aclk);
    chk("irq_req", irq_req, e);
    @(posedge aclk);
  endtask
  task automatic take(input int i);
    do @(negedge aclk); while (src_ack === 11'h0);
    chk("src_ack", src_ack, 11'h1 << i);
    @(negedge aclk);
    chk("pc_value", pc_value, VT[i]);
    @(posedge aclk);
  endtask
  task automatic t_regs();
    rd(A_MAIN, 8'h00, RESP_OKAY);
    rd(A_SEC, 8'hA0, RESP_OKAY);
    rd(A_LVL, 8'h00, RESP_OKAY);
    wr(A_LVL, 8'hFF, RESP_OKAY);
    rd(A_LVL, 8'h7F, RESP_OKAY);
    wr(A_SEC, 8'h77, RESP_OKAY);
    rd(A_SEC, 8'hF7, RESP_OKAY);
    wr(12'h010, 8'h55, RESP_DECERR);
    rd(12'h010, 8'h00, RESP_DECERR);
  endtask
  task automatic t_gate();
    wr(A_LVL, 8'h00, RESP_OKAY);
    wr(A_MAIN, 8'h7F, RESP_OKAY);
    fire(11'h7FF);
    idle(1'b0);
    wr(A_MAIN, 8'h80, RESP_OKAY);
    wr(A_SEC, 8'h00, RESP_OKAY);
    idle(1'b0);
    wr(A_MAIN, 8'hFF, RESP_OKAY);
    idle(1'b1);
  endtask
  task automatic t_order();
    wr(A_SEC, 8'h06, RESP_OKAY);
    wr(A_WDG, 8'h01, RESP_OKAY);
    rd(A_WDG, 8'h01, RESP_OKAY);
    ack_on <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      if (i == 7) continue;
      take(i);
      ret();
    end
    idle(1'b0);
    wr(A_SEC, 8'h07, RESP_OKAY);
    take(7);
    ret();
  endtask
  task automatic t_level();
    wr(A_LVL, 8'h08, RESP_OKAY);
    fire(11'h100);
    take(8);
    chk("irq_level", irq_level, 1'b0);
    fire(11'h010);
    idle(1'b0);
    fire(11'h040);
    take(6);
    chk("irq_level", irq_level, 1'b1);
    rd(A_STS, 8'h03, RESP_OKAY);
    ret();
    idle(1'b0);
    ret();
    take(4);
    ret();
    ack_on <= 1'b0;
    fire(11'h050);
    ack_on <= 1'b1;
    take(6);
    ret();
    take(4);
    ret();
  endtask
  initial begin
    {aresetn, reti, ack_on} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, raise} = '0;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_gate();
    t_order();
    t_level();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    conclude();
  end
endmodule
